//--- pkg/dfpm_consts.vh
// dfpm_consts.vh: register map, field positions, reset values and timing counts
// for the meter frequency / peak-hold block.
// assumes: included by bare name from the design; a 200 MHz mclk.
`ifndef DFPM_CONSTS_VH
`define DFPM_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// clock and timing
`define DFPM_CLK_MHZ          200
`define DFPM_PEAK_RST_NS      4000
`define DFPM_PEAK_RST_CYC     ((`DFPM_PEAK_RST_NS * `DFPM_CLK_MHZ) / 1000)

////////////////////////////////////////////////////////////////////////////////
// address map: haddr[6:5] picks a timer channel (0..2) or the peak group (3)
`define DFPM_GRP_PEAK         2'h3
`define DFPM_CH_CTL           3'h0
`define DFPM_CH_CLK           3'h1
`define DFPM_CH_CCTL          3'h2
`define DFPM_CH_CCR           3'h3
`define DFPM_CH_MC            3'h4
`define DFPM_CH_CNT           3'h5
`define DFPM_PK_CONF          3'h0
`define DFPM_PK_INIT          3'h1
`define DFPM_PK_STAT          3'h2
`define DFPM_PK_DCMAX         3'h3
`define DFPM_PK_DCMIN         3'h4
`define DFPM_PK_ACMAX         3'h5
`define DFPM_PK_ACMIN         3'h6

////////////////////////////////////////////////////////////////////////////////
// channel control word fields
`define DFPM_CTL_MODULE_ENABLE        0
`define DFPM_CTL_RUN          1
`define DFPM_CTL_PRESET       2
`define DFPM_CTL_ONE_SHOT_SELECT        5
// clock word: source in [2:0], divider in [6:3]
`define DFPM_SRC_SYS          3'h0
`define DFPM_SRC_XTAL         3'h1
`define DFPM_SRC_EXT          3'h4
// capture / compare control word fields
`define DFPM_CC_CAPTURE_COMPARE_SELECT          0
`define DFPM_CC_SCS           1
`define DFPM_CC_OUTPUT_SOURCE_SELECT        9
`define DFPM_CC_OUTPUT_POLARITY_INVERT       13
`define DFPM_CC_IE            14
`define DFPM_CC_IF            15
`define DFPM_TOUT_TOGGLE      3'h4
`define DFPM_TRG_SRC_EXT      2'h0
`define DFPM_EDGE_RISE        2'h1
`define DFPM_EDGE_FALL        2'h2
`define DFPM_EDGE_BOTH        2'h3

////////////////////////////////////////////////////////////////////////////////
// reset values
`define DFPM_MC_RST           16'hffff
`define DFPM_DCMAX_INIT       16'h8000
`define DFPM_DCMIN_INIT       16'h7fff
`define DFPM_ACMAX_INIT       32'h00000000
`define DFPM_ACMIN_INIT       32'hffffffff

`endif

//--- design/dfpm_meter_freq.v
// dfpm_meter_freq.v: three 16-bit capture/compare timer channels for frequency
// measurement, DC/AC peak hold and continuity status, behind an AHB-Lite slave.
// assumes: comparator, crystal and continuity levels arrive asynchronously;
// filter results and their valid strobes come from logic on mclk.
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "dfpm_consts.vh"

// Functional notes
// - channel 0 compares crystal counts, drives period output
// - channel 1 counts comparator, captures on period rise
// - channel 2 counts crystal, captures on comparator edge
// - flags clear on write one, set wins
// - separate DC and AC maximum and minimum registers
// - one enable bit; update beyond held extremes
// - enable changes never clear peak registers
// - peak reset restores initial values after 4 us
// - AC peak width follows square bit; root bit set stops AC updates
// - continuity status reads one while continuity detected
// - square select picks mean square else absolute
module dfpm_meter_freq
(
   input  wire        mclk,
   input  wire        nrst,
   input  wire        clk_en,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp,
   input  wire        comparator_in,
   input  wire        crystal_clk_in,
   input  wire        continuity_in,
   input  wire [15:0] dc_result,
   input  wire        dc_valid,
   input  wire [31:0] ac_result,
   input  wire        ac_valid,
   output wire        reference_period_output,
   output reg         continuity_status,
   output wire [2:0]  capture_compare_event
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; the first stage feeds only the second
   reg  [2:0] comp_sync_r;    // comparator: two sync stages plus edge history
   reg  [2:0] xtal_sync_r;    // crystal clock: same structure
   reg        cont_s1_r;      // continuity first stage
   wire       comp_rise;      // comparator rising edge, mclk domain
   wire       xtal_rise;      // crystal tick, mclk domain

   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         comp_sync_r       <= 3'h0;
         xtal_sync_r       <= 3'h0;
         cont_s1_r         <= 1'b0;
         continuity_status <= 1'b0;
      end
      else if (clk_en)
      begin
         comp_sync_r       <= {comp_sync_r[1:0], comparator_in};
         xtal_sync_r       <= {xtal_sync_r[1:0], crystal_clk_in};
         cont_s1_r         <= continuity_in;
         continuity_status <= cont_s1_r;
      end
   end

   assign comp_rise = comp_sync_r[1] & ~comp_sync_r[2];
   assign xtal_rise = xtal_sync_r[1] & ~xtal_sync_r[2];

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: writes land in the data phase, reads take one wait state
   // so a read right behind a write to the same word sees the new value
   reg        wr_pend_r;      // write data phase in progress
   reg        rd_pend_r;      // read data phase, wait cycle
   reg  [7:0] dp_addr_r;      // address latched from the address phase
   wire       addr_ok;        // valid transfer accepted this edge
   wire       wr_go;          // write data is on hwdata now
   wire [1:0] wr_grp;         // channel or peak group of the write
   wire [2:0] wr_reg;         // word within the group
   reg  [31:0] rd_mux;        // read data selected from dp_addr_r

   assign addr_ok   = hsel & htrans[1] & hready & ~rd_pend_r;
   assign wr_go     = wr_pend_r & clk_en;
   assign wr_grp    = dp_addr_r[6:5];
   assign wr_reg    = dp_addr_r[4:2];
   assign hreadyout = clk_en & ~rd_pend_r;   // frozen block holds the bus
   assign hresp     = 1'b0;

   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         dp_addr_r <= 8'h00;
         hrdata    <= 32'h00000000;
      end
      else if (clk_en)
      begin
         wr_pend_r <= addr_ok & hwrite;
         rd_pend_r <= addr_ok & ~hwrite;
         if (addr_ok)
            dp_addr_r <= haddr[7:0];
         if (rd_pend_r)
            hrdata <= rd_mux;                 // unmapped words read zero
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // timer channels; wiring between them is fixed inside the meter
   wire [2:0]  ext_clk_rise;  // external clock per channel
   wire [2:0]  trig_in;       // external capture trigger per channel
   wire [2:0]  tout;          // timer outputs
   wire [31:0] ch_rd [0:2];   // read word per channel

   assign ext_clk_rise = {1'b0, comp_rise, 1'b0};
   assign trig_in      = {comp_sync_r[1], tout[0], 1'b0};
   assign reference_period_output = tout[0];

   genvar ch;
   generate
      for (ch = 0; ch < 3; ch = ch + 1)
      begin : g_ch
         reg  [5:0]  ctl_r;    // enable, run, one-shot
         reg  [6:0]  clk_r;    // source select and divider code
         reg  [13:0] cctl_r;   // capture/compare control fields
         reg         ie_r;     // interrupt enable
         reg         flag_r;   // capture/compare flag
         reg  [15:0] ccr_r;    // compare value or captured count
         reg  [15:0] mc_r;     // counter maximum
         reg  [15:0] cnt_r;    // counter
         reg         tout_r;   // timer output
         reg         trig_d_r; // previous trigger level
         wire        wr_me;    // this channel is written now
         wire        src_tick, tick, capture_compare_select;  // source tick, counted tick, capture mode
         wire [15:0] top;                   // wrap point of the counter
         wire        wrap, match;           // counter wraps, compare match
         wire        t_rise, t_fall;        // trigger edges
         reg         cap_ev;

         assign wr_me = wr_go & (wr_grp == ch);
         assign capture_compare_select  = cctl_r[`DFPM_CC_CAPTURE_COMPARE_SELECT];
         assign src_tick = (clk_r[2:0] == `DFPM_SRC_SYS)  ? 1'b1 :
                           (clk_r[2:0] == `DFPM_SRC_XTAL) ? xtal_rise :
                           (clk_r[2:0] == `DFPM_SRC_EXT)  ? ext_clk_rise[ch] : 1'b0;
         assign tick  = ctl_r[`DFPM_CTL_MODULE_ENABLE] & ctl_r[`DFPM_CTL_RUN] & src_tick;
         // compare mode wraps at the compare value so match and max coincide
         assign top   = capture_compare_select ? mc_r : ccr_r;
         assign wrap  = tick & (cnt_r >= top);
         assign match = tick & ~capture_compare_select & (cnt_r == ccr_r);
         assign t_rise = trig_in[ch] & ~trig_d_r;
         assign t_fall = ~trig_in[ch] & trig_d_r;

         // trigger edge select; the trigger is already synchronised upstream
         always @*
         begin
            cap_ev = 1'b0;
            if (capture_compare_select && ctl_r[`DFPM_CTL_MODULE_ENABLE] && cctl_r[3:2] == `DFPM_TRG_SRC_EXT)
            begin
               case (cctl_r[5:4])
                  `DFPM_EDGE_RISE: cap_ev = t_rise;
                  `DFPM_EDGE_FALL: cap_ev = t_fall;
                  `DFPM_EDGE_BOTH: cap_ev = t_rise | t_fall;
                  default:         cap_ev = 1'b0;
               endcase
            end
         end

         // registers, counter, output and flag of one channel
         always @(posedge mclk or negedge nrst)
         begin
            if (!nrst)
            begin
               ctl_r    <= 6'h00;
               clk_r    <= 7'h00;
               cctl_r   <= 14'h0000;
               ie_r     <= 1'b0;
               flag_r   <= 1'b0;
               ccr_r    <= 16'h0000;
               mc_r     <= `DFPM_MC_RST;
               cnt_r    <= 16'h0000;
               tout_r   <= 1'b0;
               trig_d_r <= 1'b0;
            end
            else if (clk_en)
            begin
               trig_d_r <= trig_in[ch];
               // counting; a one-shot run stops at the wrap
               if (tick)
                  cnt_r <= wrap ? 16'h0000 : cnt_r + 16'h0001;
               if (wrap && ctl_r[`DFPM_CTL_ONE_SHOT_SELECT])
                  ctl_r[`DFPM_CTL_RUN] <= 1'b0;
               // toggle output on match (and max, which coincides here)
               if (cctl_r[12:10] == `DFPM_TOUT_TOGGLE &&
                   (match || (!cctl_r[`DFPM_CC_OUTPUT_SOURCE_SELECT] && wrap && !capture_compare_select)))
                  tout_r <= ~tout_r;
               if (cap_ev)
                  ccr_r <= cnt_r;
               // bus writes
               if (wr_me && wr_reg == `DFPM_CH_CTL)
               begin
                  ctl_r <= {hwdata[5:3], 1'b0, hwdata[1:0]};
                  if (hwdata[`DFPM_CTL_PRESET])
                  begin
                     cnt_r  <= 16'h0000;
                     tout_r <= hwdata[`DFPM_CTL_PRESET] & cctl_r[`DFPM_CC_OUTPUT_POLARITY_INVERT];
                  end
               end
               if (wr_me && wr_reg == `DFPM_CH_CLK)
                  clk_r <= hwdata[6:0];
               if (wr_me && wr_reg == `DFPM_CH_CCTL)
               begin
                  cctl_r <= hwdata[13:0];
                  ie_r   <= hwdata[`DFPM_CC_IE];
               end
               if (wr_me && wr_reg == `DFPM_CH_CCR && !cap_ev)
                  ccr_r <= hwdata[15:0];
               if (wr_me && wr_reg == `DFPM_CH_MC)
                  mc_r <= hwdata[15:0];
               // flag: a new event beats a simultaneous write-one clear
               if (match || cap_ev)
                  flag_r <= 1'b1;
               else if (wr_me && wr_reg == `DFPM_CH_CCTL && hwdata[`DFPM_CC_IF])
                  flag_r <= 1'b0;
            end
         end

         assign tout[ch] = tout_r;
         assign capture_compare_event[ch] = flag_r & ie_r;
         assign ch_rd[ch] =
            (wr_reg == `DFPM_CH_CTL)  ? {26'h0, ctl_r} :
            (wr_reg == `DFPM_CH_CLK)  ? {25'h0, clk_r} :
            (wr_reg == `DFPM_CH_CCTL) ? {16'h0, flag_r, ie_r, cctl_r} :
            (wr_reg == `DFPM_CH_CCR)  ? {16'h0, ccr_r} :
            (wr_reg == `DFPM_CH_MC)   ? {16'h0, mc_r} :
            (wr_reg == `DFPM_CH_CNT)  ? {16'h0, cnt_r} : 32'h0;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // peak hold
   localparam integer PEAK_RST_INT = `DFPM_PEAK_RST_CYC;
   localparam [9:0]   PEAK_RST_CYC = PEAK_RST_INT[9:0];  // 800 fits the countdown
   reg         peak_on_r;     // peak enable
   reg         square_select_r;
   reg         root_enable_r;
   reg  [9:0]  prst_cnt_r;    // reset countdown, nonzero while busy
   reg  [15:0] dc_max_r, dc_min_r;  // signed DC extremes
   reg  [31:0] ac_max_r, ac_min_r;  // unsigned AC extremes
   wire        pk_wr;         // peak group written now
   wire        prst_busy;
   wire [31:0] ac_val;        // AC value at the selected width
   wire        ac_ok;         // root enable set is a reserved combination

   assign pk_wr     = wr_go & (wr_grp == `DFPM_GRP_PEAK);
   assign prst_busy = (prst_cnt_r != 10'h000);
   assign ac_val    = square_select_r ? ac_result : {16'h0000, ac_result[15:0]};
   assign ac_ok     = ~root_enable_r;

   // updates are held off while a reset is pending so it cannot be undone
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         peak_on_r       <= 1'b0;
         square_select_r <= 1'b0;
         root_enable_r   <= 1'b0;
         prst_cnt_r      <= 10'h000;
         dc_max_r        <= `DFPM_DCMAX_INIT;
         dc_min_r        <= `DFPM_DCMIN_INIT;
         ac_max_r        <= `DFPM_ACMAX_INIT;
         ac_min_r        <= `DFPM_ACMIN_INIT;
      end
      else if (clk_en)
      begin
         // enable, square select and root enable bits only; held values untouched
         if (pk_wr && wr_reg == `DFPM_PK_CONF)
         begin
            peak_on_r       <= hwdata[0];
            square_select_r <= hwdata[1];
            root_enable_r   <= hwdata[2];
         end
         if (pk_wr && wr_reg == `DFPM_PK_INIT && hwdata[0])
            prst_cnt_r <= PEAK_RST_CYC;
         else if (prst_busy)
            prst_cnt_r <= prst_cnt_r - 10'h001;
         if (prst_cnt_r == 10'h001)
         begin
            dc_max_r <= `DFPM_DCMAX_INIT;
            dc_min_r <= `DFPM_DCMIN_INIT;
            ac_max_r <= `DFPM_ACMAX_INIT;
            ac_min_r <= `DFPM_ACMIN_INIT;
         end
         else if (peak_on_r && !prst_busy)
         begin
            // DC comb results are signed
            if (dc_valid && $signed(dc_result) > $signed(dc_max_r))
               dc_max_r <= dc_result;
            if (dc_valid && $signed(dc_result) < $signed(dc_min_r))
               dc_min_r <= dc_result;
            if (ac_valid && ac_ok && ac_val > ac_max_r)
               ac_max_r <= ac_val;
            if (ac_valid && ac_ok && ac_val < ac_min_r)
               ac_min_r <= ac_val;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read selection for the latched data-phase address
   always @*
   begin
      rd_mux = 32'h00000000;
      if (wr_grp != `DFPM_GRP_PEAK)
         rd_mux = ch_rd[wr_grp];
      else
      begin
         case (wr_reg)
            `DFPM_PK_CONF:  rd_mux = {29'h0, root_enable_r, square_select_r, peak_on_r};
            `DFPM_PK_INIT:  rd_mux = {30'h0, prst_busy, 1'b0};
            `DFPM_PK_STAT:  rd_mux = {31'h0, continuity_status};
            `DFPM_PK_DCMAX: rd_mux = {16'h0, dc_max_r};
            `DFPM_PK_DCMIN: rd_mux = {16'h0, dc_min_r};
            `DFPM_PK_ACMAX: rd_mux = ac_max_r;
            `DFPM_PK_ACMIN: rd_mux = ac_min_r;
            default:        rd_mux = 32'h00000000;
         endcase
      end
   end

endmodule // dfpm_meter_freq

//--- testbench/dfpm_meter_freq_props.sv
// dfpm_meter_freq_props.sv: port-level checks for the meter frequency block
// assumes: bound onto dfpm_meter_freq, one mclk domain, hready tied to hreadyout
`timescale 1ns/1ps
module dfpm_meter_freq_props
(
   input wire        mclk,
   input wire        nrst,
   input wire        clk_en,
   input wire        hsel,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire        hreadyout,
   input wire        hresp,
   input wire [31:0] hrdata,
   input wire        crystal_clk_in,
   input wire        continuity_in,
   input wire        continuity_status,
   input wire        reference_period_output
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////////////
   wire       take_w = hsel & htrans[1] & hready & clk_en; // transfer taken this edge
   reg        xtal_d_r;                                      // last crystal level seen
   reg  [3:0] xtal_age_r;                                    // cycles since crystal rise
   // age saturates so a stopped crystal never looks fresh
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         xtal_d_r   <= 1'b0;
         xtal_age_r <= 4'hf;
      end
      else
      begin
         xtal_d_r <= crystal_clk_in;
         if (crystal_clk_in & ~xtal_d_r)
            xtal_age_r <= 4'h0;
         else if (xtal_age_r != 4'hf)
            xtal_age_r <= xtal_age_r + 4'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   hresp_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
   read_wait_a: assert property (take_w && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   write_nowait_a: assert property (take_w && hwrite |=> hreadyout)
      else $error("write stalled");
   ready_cause_a: assert property (clk_en && !hreadyout |-> $past(take_w && !hwrite))
      else $error("wait state without read");
   stall_ready_a: assert property (!clk_en |-> !hreadyout) else $error("ready while frozen");
   rdata_hold_a: assert property ($changed(hrdata) |-> $past(take_w && !hwrite, 2))
      else $error("read data moved without read");
   cont_follow_a: assert property ($past(clk_en) && $past(clk_en, 2) |->
      continuity_status == $past(continuity_in, 2))
      else $error("continuity status lag wrong");
   ref_toggle_a: assert property ($changed(reference_period_output)
      && !$past(take_w && hwrite, 2) |-> xtal_age_r < 4'h8)
      else $error("period output moved without crystal tick");
endmodule // dfpm_meter_freq_props

bind dfpm_meter_freq dfpm_meter_freq_props u_dfpm_meter_freq_props
(
   .mclk(mclk), .nrst(nrst), .clk_en(clk_en), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .crystal_clk_in(crystal_clk_in), .continuity_in(continuity_in),
   .continuity_status(continuity_status), .reference_period_output(reference_period_output)
);

//--- testbench/dfpm_far_side.sv
// dfpm_far_side.sv: crystal oscillator and window comparator seen by the block
// assumes: times in ns; crystal runs free, comparator idles low when off
`timescale 1ns/1ps
module dfpm_far_side
#(
   parameter XTAL_HALF_NS = 50,  // crystal scaled up to keep the run short
   parameter CMP_HALF_NS  = 250  // comparator half period
)
(
   input  wire cmp_on,
   output reg  crystal_clk_in,
   output reg  comparator_in
);
   ////////////////////////////////////////////////////////////////////////////////
   // crystal: odd offset keeps its edges clear of mclk edges
   initial
   begin
      crystal_clk_in = 1'b0;
      #3;
      forever #(XTAL_HALF_NS) crystal_clk_in = ~crystal_clk_in;
   end
   // comparator square wave; stays on its grid so counts are exact
   initial
   begin
      comparator_in = 1'b0;
      #7;
      forever
      begin
         #(CMP_HALF_NS);
         comparator_in = cmp_on ? ~comparator_in : 1'b0;
      end
   end
endmodule // dfpm_far_side

//--- testbench/tb_dfpm_meter_freq.sv
// tb_dfpm_meter_freq.sv: self-checking bench for the meter frequency block
// assumes: dfpm_consts.vh on the include path; far-side model and checker compiled
`timescale 1ns/1ps
`include "dfpm_consts.vh"
module tb_dfpm_meter_freq;
   reg         mclk, nrst, clk_en, hsel, hwrite, cmp_on, continuity_in, dc_valid, ac_valid;
   reg  [31:0] haddr, hwdata, ac_result, rd_v, a_v, p_v, f_v;
   reg  [1:0]  htrans;
   reg  [15:0] dc_result;
   wire [31:0] hrdata;
   wire        hreadyout, hresp, reference_period_output, continuity_status;
   wire        crystal_clk_in, comparator_in;
   wire [2:0]  capture_compare_event;
   integer     n_fail, tests_run, cyc, t0;
   ////////////////////////////////////////////////////////////////////////////////
   dfpm_meter_freq u_dfpm_meter_freq
   (
      .mclk(mclk), .nrst(nrst), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .comparator_in(comparator_in), .crystal_clk_in(crystal_clk_in),
      .continuity_in(continuity_in), .dc_result(dc_result), .dc_valid(dc_valid),
      .ac_result(ac_result), .ac_valid(ac_valid),
      .reference_period_output(reference_period_output),
      .continuity_status(continuity_status), .capture_compare_event(capture_compare_event)
   );
   dfpm_far_side u_dfpm_far_side
   (
      .cmp_on(cmp_on), .crystal_clk_in(crystal_clk_in), .comparator_in(comparator_in)
   );
   // 200 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // hang guard: whole run needs well under this many cycles
   always @(posedge mclk)
   begin
      cyc = cyc + 1;
      if (cyc == 30000)
      begin
         n_fail = n_fail + 1;
         test_done;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task test_done;
   begin
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
   begin
      tests_run = tests_run + 1;
      if (got !== exp)
         begin
            n_fail = n_fail + 1;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
         end
   end
   endtask
   // ready is looked at before the edge, so the edge's own updates never race it
   task wait_rdy;
   begin
      @(negedge mclk);
      while (hreadyout !== 1'b1) @(negedge mclk);
      @(posedge mclk);
   end
   endtask
   task bus_wr(input [31:0] a, input [31:0] d);
   begin
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= 1'b1;
      wait_rdy;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
   end
   endtask
   // read data stands until the next read, so it is safe to take after the edge
   task bus_rd(input [31:0] a);
   begin
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= 1'b0;
      wait_rdy;
      htrans <= 2'h0;
      wait_rdy;
      rd_v = hrdata;
   end
   endtask
   task rdchk(input [31:0] a, input [31:0] exp);
   begin
      bus_rd(a);
      chk(rd_v, exp);
   end
   endtask
   // one filter result on both paths
   task push(input [15:0] d, input [31:0] a);
   begin
      dc_result <= d;
      ac_result <= a;
      dc_valid  <= 1'b1;
      ac_valid  <= 1'b1;
      @(posedge mclk);
      dc_valid  <= 1'b0;
      ac_valid  <= 1'b0;
      @(posedge mclk);
   end
   endtask
   task ev_wait(input integer i);
   begin
      @(negedge mclk);
      while (capture_compare_event[i] !== 1'b1) @(negedge mclk);
      @(posedge mclk);
   end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_reset_vals;
   begin
      rdchk(32'h6c, {16'h0, `DFPM_DCMAX_INIT});
      rdchk(32'h70, {16'h0, `DFPM_DCMIN_INIT});
      rdchk(32'h74, `DFPM_ACMAX_INIT);
      rdchk(32'h78, `DFPM_ACMIN_INIT);
      rdchk(32'h30, {16'h0, `DFPM_MC_RST});
      rdchk(32'h7c, 32'h0);
      bus_wr(32'h14, 32'h1234);
      rdchk(32'h14, 32'h0);
      clk_en <= 1'b0;
      repeat (3) @(posedge mclk);
      chk({31'h0, hreadyout}, 32'h0);
      clk_en <= 1'b1;
      $display("test reset values done");
   end
   endtask
   task t_continuity;
   begin
      continuity_in <= 1'b1;
      repeat (4) @(posedge mclk);
      chk({31'h0, continuity_status}, 32'h1);
      rdchk(32'h68, 32'h1);
      continuity_in <= 1'b0;
      repeat (4) @(posedge mclk);
      rdchk(32'h68, 32'h0);
      $display("test continuity done");
   end
   endtask
   task t_peak;
   begin
      push(16'h0009, 32'h00000000);
      bus_wr(32'h60, 32'h3);
      push(16'h0005, 32'h12345678);
      push(16'hfffd, 32'h00000010);
      push(16'h0002, 32'h00001000);
      rdchk(32'h6c, 32'h5);
      rdchk(32'h70, 32'hfffd);
      rdchk(32'h74, 32'h12345678);
      rdchk(32'h78, 32'h10);
      bus_wr(32'h60, 32'h2);
      push(16'h0100, 32'h7fffffff);
      rdchk(32'h6c, 32'h5);
      rdchk(32'h74, 32'h12345678);
      bus_wr(32'h64, 32'h1);
      rdchk(32'h64, 32'h2);
      repeat (`DFPM_PEAK_RST_CYC) @(posedge mclk);
      rdchk(32'h64, 32'h0);
      rdchk(32'h6c, {16'h0, `DFPM_DCMAX_INIT});
      rdchk(32'h78, `DFPM_ACMIN_INIT);
      bus_wr(32'h60, 32'h1);
      push(16'h0003, 32'habcd0020);
      rdchk(32'h74, 32'h20);
      bus_wr(32'h60, 32'h5);
      push(16'h0003, 32'h00000001);
      rdchk(32'h78, 32'h20);
      $display("test peak hold done");
   end
   endtask
   // compare value scaled down from the half-second setting to keep the run short
   task t_freq;
   begin
      cmp_on <= 1'b1;
      bus_wr(32'h24, 32'h4);
      bus_wr(32'h20, 32'h5);
      bus_wr(32'h28, 32'hc013);
      bus_wr(32'h30, 32'hffff);
      bus_wr(32'h44, 32'h1);
      bus_wr(32'h40, 32'h5);
      bus_wr(32'h48, 32'hc013);
      bus_wr(32'h50, 32'hffff);
      bus_wr(32'h04, 32'h1);
      bus_wr(32'h00, 32'h5);
      bus_wr(32'h08, 32'hd100);
      bus_wr(32'h0c, 32'h9);
      bus_wr(32'h20, 32'h3);
      bus_wr(32'h40, 32'h3);
      bus_wr(32'h00, 32'h3);
      ev_wait(1);
      bus_wr(32'h28, 32'hc013);
      rdchk(32'h28, 32'h4013);
      ev_wait(1);
      bus_rd(32'h2c);
      a_v = rd_v;
      bus_wr(32'h28, 32'hc013);
      ev_wait(1);
      rdchk(32'h2c, a_v + 32'h4);
      p_v = rd_v - a_v;
      bus_wr(32'h48, 32'hc013);
      ev_wait(2);
      bus_rd(32'h4c);
      a_v = rd_v;
      bus_wr(32'h48, 32'hc013);
      ev_wait(2);
      rdchk(32'h4c, a_v + 32'h5);
      // few pulses per period: divide by crystal counts between two pulses
      if (p_v >= 32'd4000)
         f_v = (32'd32768 * p_v) / 32'd18;
      else
         f_v = 32'd32768 / (rd_v - a_v);
      chk(f_v, 32'd6553);
      @(posedge reference_period_output);
      t0 = $time;
      @(posedge reference_period_output);
      chk(($time - t0) / 5, 32'd400);
      chk({31'h0, capture_compare_event[0]}, 32'h1);
      $display("test frequency done");
   end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {n_fail, tests_run, cyc, t0} = 0;
      {nrst, hsel, hwrite, cmp_on, continuity_in, dc_valid, ac_valid} = 7'h0;
      {haddr, hwdata, ac_result, rd_v, a_v, p_v, f_v, htrans, dc_result} = 0;
      clk_en = 1'b1;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      t_reset_vals;
      t_continuity;
      t_peak;
      t_freq;
      test_done;
   end
endmodule // tb_dfpm_meter_freq
